// ===== hdl/flash_lock_host.sv
`timescale 1ns/100ps
`default_nettype none
module flash_lock_host
#(
   // command codes: arbitrary defaults, set to the part's values
   parameter logic [7:0] CODE_READ_ARRAY    = 8'h11,
   parameter logic [7:0] CODE_READ_STATUS   = 8'h12,
   parameter logic [7:0] CODE_SUSPEND       = 8'h13,
   parameter logic [7:0] CODE_RESUME        = 8'h14,
   parameter logic [7:0] CODE_LOCK_SETUP    = 8'h15,
   parameter logic [7:0] CODE_BLOCK_CONFIRM = 8'h16,
   parameter logic [7:0] CODE_MASTER_CONF   = 8'h17,
   parameter logic [7:0] CODE_CLEAR_CONFIRM = 8'h18
)
(
   input  wire logic                      clk,
   input  wire logic                      reset,
   input  wire logic [31:0]               awaddr,
   input  wire logic                      awvalid,
   output logic                           awready,
   input  wire logic [31:0]               wdata,
   input  wire logic [3:0]                wstrb,
   input  wire logic                      wvalid,
   output logic                           wready,
   output logic [1:0]                     bresp,
   output logic                           bvalid,
   input  wire logic                      bready,
   input  wire logic [31:0]               araddr,
   input  wire logic                      arvalid,
   output logic                           arready,
   output logic [31:0]                    rdata,
   output logic [1:0]                     rresp,
   output logic                           rvalid,
   input  wire logic                      rready,
   output var flash_host_pkg::flash_out_t flash_o,
   input  wire logic [7:0]                dq_in,
   input  wire logic                      ready_busy
);
   flash_host_pkg::state_t     state_r, state_nxt;
   flash_host_pkg::op_t        op_r, op_nxt;
   flash_host_pkg::flash_out_t fo_r, fo_nxt;
   logic [1:0]  ph_r, ph_nxt;
   logic [3:0]  cnt_r, cnt_nxt;
   logic [19:0] addr_r, addr_nxt;
   logic [1:0]  ctrl_r, ctrl_nxt, ctrl_lat_r, ctrl_lat_nxt;
   logic [7:0]  stat_r, stat_nxt;
   logic        susp_r, susp_nxt, refused_r, refused_nxt, undef_r, undef_nxt;
   logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic        wr_fire, rd_fire, allowed, abort, lock_op, err_seen, err_kept, two_cycle, waits;
   logic [7:0]  code1, code2, code_now;
   flash_host_pkg::op_t req_op;

   assign awready = awvalid & wvalid & ~bvalid_r;
   assign wready  = awvalid & wvalid & ~bvalid_r;
   assign arready = ~rvalid_r;
   assign wr_fire = awvalid & wvalid & ~bvalid_r;
   assign rd_fire = arvalid & ~rvalid_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign rvalid  = rvalid_r;
   assign rresp   = rresp_r;
   assign rdata   = rdata_r;
   assign flash_o = fo_r;
   assign req_op  = flash_host_pkg::op_t'(wdata[2:0]);

   // a reset or override change under way would abort the device operation
   assign abort   = (state_r != flash_host_pkg::S_IDLE) && (ctrl_r != ctrl_lat_r);
   assign lock_op = (op_r == flash_host_pkg::OP_SET_BLOCK) || (op_r == flash_host_pkg::OP_SET_MASTER)
                    || (op_r == flash_host_pkg::OP_CLEAR_LOCKS);
   assign err_seen = dq_in[flash_host_pkg::SR_ECL_BIT] | dq_in[flash_host_pkg::SR_WSL_BIT]
                     | dq_in[flash_host_pkg::SR_SUPPLY_BIT] | dq_in[flash_host_pkg::SR_LOCK_BIT];
   // the pins are released in the last read phase, so the decision uses the latched byte
   assign err_kept = stat_r[flash_host_pkg::SR_ECL_BIT] | stat_r[flash_host_pkg::SR_WSL_BIT]
                     | stat_r[flash_host_pkg::SR_SUPPLY_BIT] | stat_r[flash_host_pkg::SR_LOCK_BIT];

   always_comb
   begin
      allowed = (state_r == flash_host_pkg::S_IDLE) && !ctrl_r[flash_host_pkg::CTRL_RST_BIT];
      if (susp_r && !(req_op == flash_host_pkg::OP_READ_ARRAY || req_op == flash_host_pkg::OP_READ_STATUS
                      || req_op == flash_host_pkg::OP_RESUME))
      begin
         allowed = 1'b0;
      end
   end

   // command codes of the operation that is running or about to run
   always_comb
   begin
      code1     = CODE_READ_ARRAY;
      code2     = CODE_READ_ARRAY;
      two_cycle = 1'b0;
      waits     = 1'b0;
      case (op_nxt)
         flash_host_pkg::OP_READ_STATUS:  code1 = CODE_READ_STATUS;
         flash_host_pkg::OP_CLEAR_STATUS: code1 = flash_host_pkg::CMD_CLEAR_STATUS;
         flash_host_pkg::OP_SUSPEND:
         begin
            code1 = CODE_SUSPEND;
            waits = 1'b1;
         end
         flash_host_pkg::OP_RESUME:       code1 = CODE_RESUME;
         flash_host_pkg::OP_SET_BLOCK:
         begin
            code1     = CODE_LOCK_SETUP;
            code2     = CODE_BLOCK_CONFIRM;
            two_cycle = 1'b1;
            waits     = 1'b1;
         end
         flash_host_pkg::OP_SET_MASTER:
         begin
            code1     = CODE_LOCK_SETUP;
            code2     = CODE_MASTER_CONF;
            two_cycle = 1'b1;
            waits     = 1'b1;
         end
         flash_host_pkg::OP_CLEAR_LOCKS:
         begin
            code1     = CODE_LOCK_SETUP;
            code2     = CODE_CLEAR_CONFIRM;
            two_cycle = 1'b1;
            waits     = 1'b1;
         end
         default:                         code1 = CODE_READ_ARRAY;
      endcase
   end

   // sequencer and register file
   always_comb
   begin
      state_nxt    = state_r;
      op_nxt       = op_r;
      ph_nxt       = ph_r;
      cnt_nxt      = cnt_r;
      addr_nxt     = addr_r;
      ctrl_nxt     = ctrl_r;
      ctrl_lat_nxt = ctrl_lat_r;
      stat_nxt     = stat_r;
      susp_nxt     = susp_r;
      refused_nxt  = refused_r;
      undef_nxt    = undef_r;
      bvalid_nxt   = bvalid_r & ~bready;
      bresp_nxt    = bresp_r;
      if (wr_fire)
      begin
         bvalid_nxt = 1'b1;
         bresp_nxt  = flash_host_pkg::AXI_OKAY;
         if (awaddr[31:4] != 28'h0000000)
         begin
            bresp_nxt = flash_host_pkg::AXI_SLVERR;
         end
         else if (awaddr[3:0] == flash_host_pkg::REG_CMD)
         begin
            if (allowed && wstrb[0])
            begin
               op_nxt       = req_op;
               state_nxt    = flash_host_pkg::S_CMD1;
               ph_nxt       = 2'h0;
               ctrl_lat_nxt = ctrl_r;
               refused_nxt  = 1'b0;
            end
            else
            begin
               refused_nxt = 1'b1;
               bresp_nxt   = flash_host_pkg::AXI_SLVERR;
            end
         end
         else if (awaddr[3:0] == flash_host_pkg::REG_ADDR)
         begin
            for (int i = 0; i < 2; i++)
            begin
               if (wstrb[i])
               begin
                  addr_nxt[i*8 +: 8] = wdata[i*8 +: 8];
               end
            end
            addr_nxt[19:16] = wstrb[2] ? wdata[19:16] : addr_r[19:16];
         end
         else if (awaddr[3:0] == flash_host_pkg::REG_CTRL)
         begin
            if (wstrb[0])
            begin
               ctrl_nxt = wdata[1:0];
            end
         end
         else if (awaddr[3:0] != flash_host_pkg::REG_STATUS)
         begin
            bresp_nxt = flash_host_pkg::AXI_SLVERR;
         end
      end
      if (state_r != flash_host_pkg::S_IDLE)
      begin
         ph_nxt = ph_r + 2'h1;
      end
      case (state_r)
         // command acceptance above picks the next state
         flash_host_pkg::S_IDLE:
            cnt_nxt = 4'h0;
         flash_host_pkg::S_CMD1:
            if (ph_r == 2'h3)
            begin
               if (two_cycle)
               begin
                  state_nxt = flash_host_pkg::S_CMD2;
               end
               else if (waits)
               begin
                  state_nxt = flash_host_pkg::S_SETTLE;
                  cnt_nxt   = 4'h0;
               end
               else if (op_r == flash_host_pkg::OP_READ_STATUS)
               begin
                  state_nxt = flash_host_pkg::S_READ;
               end
               else
               begin
                  state_nxt = flash_host_pkg::S_IDLE;
                  if (op_r == flash_host_pkg::OP_RESUME)
                  begin
                     susp_nxt = 1'b0;
                  end
               end
            end
         flash_host_pkg::S_CMD2:
            if (ph_r == 2'h3)
            begin
               state_nxt = flash_host_pkg::S_SETTLE;
               cnt_nxt   = 4'h0;
            end
         flash_host_pkg::S_SETTLE:
         begin
            ph_nxt  = 2'h0;
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == flash_host_pkg::SETTLE_CYC)
            begin
               state_nxt = flash_host_pkg::S_POLL;
            end
         end
         flash_host_pkg::S_POLL:
         begin
            ph_nxt = 2'h0;
            if (ready_busy)
            begin
               state_nxt = flash_host_pkg::S_READ;
            end
         end
         flash_host_pkg::S_READ:
            if (ph_r == 2'h2)
            begin
               stat_nxt = dq_in;
               if (op_r == flash_host_pkg::OP_SUSPEND)
               begin
                  susp_nxt = dq_in[flash_host_pkg::SR_SUSP_BIT] & dq_in[flash_host_pkg::SR_READY_BIT];
               end
               if (op_r == flash_host_pkg::OP_CLEAR_LOCKS)
               begin
                  undef_nxt = undef_r & err_seen;
               end
            end
            else if (ph_r == 2'h3)
            begin
               // errors are kept in stat_r for software; after a lock operation they are then cleared in the part
               state_nxt = (lock_op && err_kept) ? flash_host_pkg::S_CLEAR : flash_host_pkg::S_IDLE;
            end
         flash_host_pkg::S_CLEAR:
            if (ph_r == 2'h3)
            begin
               state_nxt = flash_host_pkg::S_IDLE;
            end
         default:
            state_nxt = flash_host_pkg::S_IDLE;
      endcase
      if (abort)
      begin
         state_nxt = flash_host_pkg::S_IDLE;
         ph_nxt    = 2'h0;
         if (op_r == flash_host_pkg::OP_CLEAR_LOCKS)
         begin
            undef_nxt = 1'b1;
         end
      end
      code_now = (state_nxt == flash_host_pkg::S_CMD2) ? code2 : code1;
      if (state_nxt == flash_host_pkg::S_CLEAR)
      begin
         code_now = flash_host_pkg::CMD_CLEAR_STATUS;
      end
      fo_nxt        = '{addr: addr_nxt, dq_out: code_now, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                        rp_n: ~ctrl_nxt[flash_host_pkg::CTRL_RST_BIT], rp_hv: ctrl_nxt[flash_host_pkg::CTRL_HV_BIT]};
      if (state_nxt == flash_host_pkg::S_CMD1 || state_nxt == flash_host_pkg::S_CMD2
          || state_nxt == flash_host_pkg::S_CLEAR)
      begin
         fo_nxt.ce_n  = 1'b0;
         fo_nxt.dq_oe = 1'b1;
         fo_nxt.we_n  = !(ph_nxt == 2'h1 || ph_nxt == 2'h2);
      end
      else if (state_nxt == flash_host_pkg::S_READ)
      begin
         fo_nxt.ce_n = 1'b0;
         fo_nxt.oe_n = !(ph_nxt == 2'h1 || ph_nxt == 2'h2);
      end
   end

   // read side of the register slave
   always_comb
   begin
      rvalid_nxt = rvalid_r & ~rready;
      rresp_nxt  = rresp_r;
      rdata_nxt  = rdata_r;
      if (rd_fire)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = flash_host_pkg::AXI_OKAY;
         rdata_nxt  = 32'h00000000;
         if (araddr[31:4] != 28'h0000000)
         begin
            rresp_nxt = flash_host_pkg::AXI_SLVERR;
         end
         else if (araddr[3:0] == flash_host_pkg::REG_CMD)
         begin
            rdata_nxt[2:0] = op_r;
         end
         else if (araddr[3:0] == flash_host_pkg::REG_ADDR)
         begin
            rdata_nxt[19:0] = addr_r;
         end
         else if (araddr[3:0] == flash_host_pkg::REG_CTRL)
         begin
            rdata_nxt[1:0] = ctrl_r;
         end
         else if (araddr[3:0] == flash_host_pkg::REG_STATUS)
         begin
            rdata_nxt[7:0] = stat_r;
            rdata_nxt[flash_host_pkg::ST_BUSY_BIT]    = (state_r != flash_host_pkg::S_IDLE);
            rdata_nxt[flash_host_pkg::ST_SUSP_BIT]    = susp_r;
            rdata_nxt[flash_host_pkg::ST_REFUSED_BIT] = refused_r;
            rdata_nxt[flash_host_pkg::ST_UNDEF_BIT]   = undef_r;
            rdata_nxt[flash_host_pkg::ST_RDY_PIN_BIT] = ready_busy;
         end
         else
         begin
            rresp_nxt = flash_host_pkg::AXI_SLVERR;
         end
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_r    <= flash_host_pkg::S_IDLE;
         op_r       <= flash_host_pkg::OP_READ_ARRAY;
         ph_r       <= 2'h0;
         cnt_r      <= 4'h0;
         addr_r     <= 20'h00000;
         ctrl_r     <= flash_host_pkg::CTRL_RESET_VAL;
         ctrl_lat_r <= flash_host_pkg::CTRL_RESET_VAL;
         stat_r     <= 8'h00;
         susp_r     <= 1'b0;
         refused_r  <= 1'b0;
         undef_r    <= 1'b0;
         bvalid_r   <= 1'b0;
         bresp_r    <= 2'h0;
         rvalid_r   <= 1'b0;
         rresp_r    <= 2'h0;
         rdata_r    <= 32'h00000000;
         fo_r       <= '{addr: 20'h00000, dq_out: 8'h00, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1,
                         oe_n: 1'b1, rp_n: 1'b1, rp_hv: 1'b0};
      end
      else
      begin
         state_r    <= state_nxt;
         op_r       <= op_nxt;
         ph_r       <= ph_nxt;
         cnt_r      <= cnt_nxt;
         addr_r     <= addr_nxt;
         ctrl_r     <= ctrl_nxt;
         ctrl_lat_r <= ctrl_lat_nxt;
         stat_r     <= stat_nxt;
         susp_r     <= susp_nxt;
         refused_r  <= refused_nxt;
         undef_r    <= undef_nxt;
         bvalid_r   <= bvalid_nxt;
         bresp_r    <= bresp_nxt;
         rvalid_r   <= rvalid_nxt;
         rresp_r    <= rresp_nxt;
         rdata_r    <= rdata_nxt;
         fo_r       <= fo_nxt;
      end
   end
endmodule
`default_nettype wire

// ===== hdl/flash_host_pkg.sv
`default_nettype none
package flash_host_pkg;

   // controller register map (byte addresses, one 32-bit word each)
   localparam logic [3:0] REG_CMD    = 4'h0;
   localparam logic [3:0] REG_ADDR   = 4'h4;
   localparam logic [3:0] REG_CTRL   = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;

   // control register fields
   localparam int CTRL_HV_BIT  = 0;
   localparam int CTRL_RST_BIT = 1;
   localparam logic [1:0] CTRL_RESET_VAL = 2'h0;

   // status register fields of the controller
   localparam int ST_BUSY_BIT    = 8;
   localparam int ST_SUSP_BIT    = 9;
   localparam int ST_REFUSED_BIT = 10;
   localparam int ST_UNDEF_BIT   = 11;
   localparam int ST_RDY_PIN_BIT = 12;

   // device status byte fields
   localparam int SR_READY_BIT  = 7;
   localparam int SR_ECL_BIT    = 5;
   localparam int SR_WSL_BIT    = 4;
   localparam int SR_SUPPLY_BIT = 3;
   localparam int SR_SUSP_BIT   = 2;
   localparam int SR_LOCK_BIT   = 1;

   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   // wait after a command write before ready_busy is trusted
   localparam int CLK_PERIOD_NS = 100;
   localparam int SETTLE_NS     = 300;
   localparam logic [3:0] SETTLE_CYC = 4'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      OP_READ_ARRAY   = 3'b000,
      OP_READ_STATUS  = 3'b001,
      OP_CLEAR_STATUS = 3'b010,
      OP_SUSPEND      = 3'b011,
      OP_RESUME       = 3'b100,
      OP_SET_BLOCK    = 3'b101,
      OP_SET_MASTER   = 3'b110,
      OP_CLEAR_LOCKS  = 3'b111
   } op_t;

   typedef enum logic [2:0] {
      S_IDLE   = 3'b000,
      S_CMD1   = 3'b001,
      S_CMD2   = 3'b010,
      S_SETTLE = 3'b011,
      S_POLL   = 3'b100,
      S_READ   = 3'b101,
      S_CLEAR  = 3'b110
   } state_t;

   typedef struct packed {
      logic [19:0] addr;
      logic [7:0]  dq_out;
      logic        dq_oe;
      logic        ce_n;
      logic        we_n;
      logic        oe_n;
      logic        rp_n;
      logic        rp_hv;
   } flash_out_t;

endpackage
`default_nettype wire

// ===== dv/flash_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model
#(
   parameter int LOCK_CYC = 6
)
(
   input  wire logic                       clk,
   input  wire flash_host_pkg::flash_out_t f,
   input  wire logic                       supply_low,
   input  wire logic                       wr_go,
   output logic [7:0]                      dq_in,
   output logic                            ready_busy
);
   localparam logic [7:0] RA = 8'h11, RS = 8'h12, SUS = 8'h13, RES = 8'h14;
   localparam logic [7:0] SET = 8'h15, BLK = 8'h16, MST = 8'h17, CLR = 8'h18;
   logic [7:0] sr = 8'h0, last = 8'h0, code = 8'h0;
   logic [1:0] lock = 2'h0;
   logic       master = 1'b0, pend = 1'b0, susp = 1'b0, we_q = 1'b1, ab = 1'b0;
   int         cnt = 0;
   wire        drive = !f.ce_n && !f.oe_n;
   wire  [7:0] st = {cnt == 0 || susp, sr[6:0]};
   // released bus shows the inverse so a stale sample cannot match
   assign dq_in = drive ? st : ~last;
   assign ready_busy = cnt == 0 || susp;
   always @(posedge clk)
   begin
      we_q <= f.we_n;
      if (drive)
         last <= st;
      if (cnt > 0 && !susp)
         cnt <= cnt - 1;
      if (wr_go)
      begin
         if (lock[f.addr[19]] && !f.rp_hv)
            sr <= sr | 8'h12;
         else
            cnt <= 40;
      end
      if (!f.we_n)
      begin
         code <= f.dq_out;
         ab <= f.addr[19];
      end
      if (f.we_n && !we_q)
      begin
         if (susp && code != RA && code != RS && code != RES)
            ;
         else if (pend)
         begin
            pend <= 1'b0;
            cnt <= LOCK_CYC;
            if (code == BLK && master && !f.rp_hv)
               sr <= sr | 8'h12;
            else if (code == BLK)
               lock[ab] <= 1'b1;
            else if (code == MST && !f.rp_hv)
               sr <= sr | 8'h12;
            else if (code == MST)
               master <= 1'b1;
            else if (code == CLR && supply_low)
               sr <= sr | 8'h28;
            else if (code == CLR && master && !f.rp_hv)
               sr <= sr | 8'h22;
            else if (code == CLR)
               lock <= 2'h0;
            else
               sr <= sr | 8'h30;
         end
         else if (code == SET)
            pend <= 1'b1;
         else if (code == 8'h50)
            sr <= sr & 8'hc5;
         else if (code == SUS && cnt > 0)
         begin
            susp <= 1'b1;
            sr[2] <= 1'b1;
         end
         else if (code == RES && susp)
         begin
            susp <= 1'b0;
            sr[2] <= 1'b0;
         end
      end
      if (!f.rp_n)
      begin
         pend <= 1'b0;
         cnt <= 0;
         susp <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== dv/flash_lock_host_sva.sv
`timescale 1ns/100ps
`default_nettype none
module flash_lock_host_sva
(
   input wire logic                       clk,
   input wire logic                       reset,
   input wire logic [31:0]                awaddr,
   input wire logic                       awvalid,
   input wire logic                       awready,
   input wire logic                       wvalid,
   input wire logic [1:0]                 bresp,
   input wire logic                       bvalid,
   input wire logic                       bready,
   input wire logic                       arvalid,
   input wire logic                       arready,
   input wire logic [31:0]                rdata,
   input wire logic                       rvalid,
   input wire logic                       rready,
   input wire flash_host_pkg::flash_out_t flash_o
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   AST_AW_ANSWER: assert property (awvalid && wvalid && awready |=> bvalid && !awready)
      else $error("write not answered");
   AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   AST_AR_ANSWER: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read not answered");
   AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   AST_UNMAPPED: assert property (awvalid && awready && awaddr[31:4] != 28'h0 |=> bresp == flash_host_pkg::AXI_SLVERR)
      else $error("unmapped write accepted");
   AST_WE_PULSE: assert property ($fell(flash_o.we_n) |-> !flash_o.ce_n && flash_o.dq_oe ##1 !flash_o.we_n ##1 flash_o.we_n)
      else $error("write strobe shape wrong");
   AST_WE_DATA: assert property (!flash_o.we_n |-> $stable(flash_o.dq_out) && $stable(flash_o.addr))
      else $error("data moved under write strobe");
   AST_NO_CONTENTION: assert property (!flash_o.oe_n |-> !flash_o.dq_oe && flash_o.we_n)
      else $error("bus driven while reading");
   AST_READ_PULSE: assert property ($fell(flash_o.oe_n) |=> !flash_o.oe_n ##1 flash_o.oe_n)
      else $error("read strobe shape wrong");
   cover property (bvalid && bresp == flash_host_pkg::AXI_SLVERR);
   cover property ($fell(flash_o.we_n) && flash_o.rp_hv);
   cover property ($fell(flash_o.oe_n));
endmodule
bind flash_lock_host flash_lock_host_sva i_sva (.clk, .reset, .awaddr, .awvalid, .awready, .wvalid, .bresp,
   .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .flash_o);
`default_nettype wire

// ===== dv/flash_lock_host_tb.sv
`timescale 1ns/100ps
`default_nettype none
module flash_lock_host_tb;
   logic        clk = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, supply_low = 1'b0, wr_go = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, st;
   logic [3:0]  wstrb = 4'h0;
   logic [1:0]  bresp, rresp, rsp;
   logic        awready, wready, bvalid, arready, rvalid, ready_busy;
   logic [7:0]  dq_in;
   int          n_errors = 0, num_checks = 0;
   flash_host_pkg::flash_out_t flash_o;
   localparam logic [31:0] CMD = 32'h0, ADR = 32'h4, CTL = 32'h8, STS = 32'hc;

   initial forever #50 clk = ~clk;

   flash_lock_host i_dut (.clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .flash_o, .dq_in,
      .ready_busy);
   flash_dev_model i_dev (.clk, .f(flash_o), .supply_low, .wr_go, .dq_in, .ready_busy);

   task give_verdict;
      if (n_errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // sampled at the falling edge: inputs only move at rising edges, so the value holds to the next one
   task automatic wait_neg(ref logic s);
      int i;
      i = 0;
      @(negedge clk);
      while (s !== 1'b1)
      begin
         i++;
         if (i > 300)
         begin
            n_errors++;
            give_verdict();
         end
         @(negedge clk);
      end
   endtask

   task axi_wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      wait_neg(awready);
      chk("wready", 32'h1, {31'h0, wready});
      @(posedge clk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      wait_neg(bvalid);
      rsp = bresp;
      @(posedge clk);
      bready <= 1'b0;
   endtask

   task axi_rd(input logic [31:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      wait_neg(arready);
      @(posedge clk);
      arvalid <= 1'b0;
      wait_neg(rvalid);
      st = rdata;
      rsp = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask

   task do_op(input logic [2:0] op);
      int i;
      i = 0;
      axi_wr(CMD, {29'h0, op});
      axi_rd(STS);
      while (st[flash_host_pkg::ST_BUSY_BIT] !== 1'b0 && i < 200)
      begin
         i++;
         axi_rd(STS);
      end
      if (i >= 200)
      begin
         n_errors++;
         give_verdict();
      end
   endtask

   task lock_op(input logic [2:0] op, input logic hv, input logic [7:0] exp);
      axi_wr(CTL, {31'h0, hv});
      do_op(op);
      chk("status byte", {24'h0, exp}, {24'h0, st[7:0]});
      chk("device errors", 32'h0, {24'h0, i_dev.sr & 8'h3a});
   endtask

   task t_regs;
      axi_rd(CTL);
      chk("ctrl reset", 32'h0, st);
      chk("read resp", {30'h0, flash_host_pkg::AXI_OKAY}, {30'h0, rsp});
      axi_wr(32'h10, 32'h1);
      chk("unmapped resp", {30'h0, flash_host_pkg::AXI_SLVERR}, {30'h0, rsp});
   endtask

   task t_set_block;
      axi_wr(ADR, 32'h0);
      lock_op(3'h5, 1'b0, 8'h80);
      chk("block lock", 32'h1, {30'h0, i_dev.lock});
   endtask

   task t_bad_master;
      lock_op(3'h6, 1'b0, 8'h92);
      chk("master clear", 32'h0, {31'h0, i_dev.master});
   endtask

   task t_low_supply;
      supply_low <= 1'b1;
      lock_op(3'h7, 1'b0, 8'ha8);
      chk("locks kept", 32'h1, {30'h0, i_dev.lock});
      supply_low <= 1'b0;
   endtask

   task t_suspend;
      @(posedge clk);
      wr_go <= 1'b1;
      @(posedge clk);
      wr_go <= 1'b0;
      @(posedge clk);
      chk("locked write flags", 32'h12, {24'h0, i_dev.sr & 8'h12});
      chk("locked write idle", 32'h1, {31'h0, ready_busy});
      do_op(3'h2);
      axi_wr(CTL, 32'h1);
      @(posedge clk);
      wr_go <= 1'b1;
      @(posedge clk);
      wr_go <= 1'b0;
      do_op(3'h3);
      chk("suspended", 32'h284, st & 32'h2ff);
      axi_wr(CMD, 32'h2);
      chk("refused resp", {30'h0, flash_host_pkg::AXI_SLVERR}, {30'h0, rsp});
      axi_rd(STS);
      chk("refused flag", 32'h1, {31'h0, st[flash_host_pkg::ST_REFUSED_BIT]});
      chk("still suspended", 32'h1, {31'h0, i_dev.susp});
      do_op(3'h0);
      chk("read array taken", 32'h0, {31'h0, st[flash_host_pkg::ST_REFUSED_BIT]});
      do_op(3'h1);
      chk("status in suspend", 32'h84, {24'h0, st[7:0]});
      do_op(3'h4);
      chk("resumed", 32'h0, {31'h0, st[flash_host_pkg::ST_SUSP_BIT]});
      chk("busy again", 32'h0, {31'h0, ready_busy});
      wait_neg(ready_busy);
   endtask

   task t_master;
      lock_op(3'h6, 1'b1, 8'h80);
      chk("master set", 32'h1, {31'h0, i_dev.master});
      lock_op(3'h5, 1'b0, 8'h92);
      lock_op(3'h7, 1'b0, 8'ha2);
      chk("locks held", 32'h1, {30'h0, i_dev.lock});
   endtask

   task t_abort;
      axi_wr(CTL, 32'h0);
      axi_wr(CMD, 32'h7);
      axi_wr(CTL, 32'h2);
      axi_rd(STS);
      chk("locks undefined", 32'h1, {31'h0, st[flash_host_pkg::ST_UNDEF_BIT]});
      axi_wr(CTL, 32'h0);
      lock_op(3'h7, 1'b1, 8'h80);
      chk("undefined cleared", 32'h0, {31'h0, st[flash_host_pkg::ST_UNDEF_BIT]});
      chk("locks cleared", 32'h0, {30'h0, i_dev.lock});
      chk("master kept", 32'h1, {31'h0, i_dev.master});
   endtask

   initial
   begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_set_block();
      t_bad_master();
      t_low_supply();
      t_suspend();
      t_master();
      t_abort();
      give_verdict();
   end
endmodule
`default_nettype wire
